// [design/isic_defs.svh]
// Purpose: named offsets, fields, reset values and timing for the
//          interrupt control block
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes:   included by the package and by every design file
`ifndef ISIC_DEFS_SVH
`define ISIC_DEFS_SVH

// register byte offsets
`define ISIC_ADDR_W 5
`define ISIC_OFF_DATA 5'h00
`define ISIC_OFF_CMD 5'h04
`define ISIC_OFF_RESULT 5'h08
`define ISIC_OFF_STATUS 5'h0C
`define ISIC_OFF_IRQ_MASK 5'h10
`define ISIC_OFF_PENDING 5'h14
`define ISIC_OFF_MASK 5'h18

// command word fields
`define ISIC_CMD_SEL_LSB 0
`define ISIC_CMD_CC_LSB 4
`define ISIC_SEL_LAST_UNIT 3'h3
`define ISIC_SEL_TIMER 3'h4
`define ISIC_CC_MASK 3'h0
`define ISIC_CC_CLEAR 3'h1
`define ISIC_CC_READ 3'h2

// status / irq mask bit positions
`define ISIC_ST_W 4
`define ISIC_ST_DONE 0
`define ISIC_ST_ERR 1
`define ISIC_ST_FIRE 2
`define ISIC_ST_DISP 3

// interrupt sources
`define ISIC_UNITS 4
`define ISIC_UNIT_IN_W 16
`define ISIC_BITS_PER_UNIT 8
`define ISIC_SRC_W 32
`define ISIC_SUB_W 6
`define ISIC_SCHED_SUB 6'h20
`define ISIC_NO_SUB 6'h3F

// timing: one timer tick is one hundredth of a second
`define ISIC_CLK_NS 5
`define ISIC_TICK_NS 10000000
`define ISIC_DIV_W 22
`define ISIC_CNT_W 14
`define ISIC_CNT_ZERO 14'h0000
`define ISIC_CNT_ONE 14'h0001

// reset values
`define ISIC_RST_WORD 32'h00000000

`endif

// [design/isic_pkg.sv]
// Purpose: state types of the interrupt control block
// Assumes: isic_defs.svh supplies the count, source, status, subroutine and divider widths
// Notes:   each module keeps its whole state in one of these structs
`include "isic_defs.svh"

package isic_pkg;

   typedef enum logic [1:0] {
      ISIC_TM_IDLE = 2'b00,
      ISIC_TM_RUN = 2'b01
   } isic_tm_state_t;

   typedef struct packed {
      isic_tm_state_t state;
      logic [`ISIC_CNT_W-1:0] period;
      logic [`ISIC_CNT_W-1:0] count;
      logic fire;
   } isic_tm_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [15:0] data_word;
      logic [15:0] result;
      logic [15:0] period_bcd;
      logic [`ISIC_SRC_W-1:0] mask;
      logic [`ISIC_SRC_W-1:0] pending;
      logic [`ISIC_SRC_W-1:0] prev_in;
      logic sched_pend;
      logic [`ISIC_ST_W-1:0] status;
      logic [`ISIC_ST_W-1:0] irq_mask;
      logic disp_valid;
      logic [`ISIC_SUB_W-1:0] disp_num;
      logic [`ISIC_DIV_W-1:0] div_cnt;
      logic tick;
   } isic_top_t;

endpackage

// [design/isic_sched_timer.sv]
// Purpose: scheduled interrupt timer counting hundredth-second ticks
// Assumes: load strobes are one-cycle and never high together
// Notes:   a zero value cancels the timer; period zero means one-shot
`timescale 1ns/1ps
`include "isic_defs.svh"

module isic_sched_timer
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // tick and loads
   input wire logic tick_in,
   input wire logic load_period_in,
   input wire logic load_delay_in,
   input wire logic [`ISIC_CNT_W-1:0] value_in,
   // results
   output logic fire_out,
   output logic running_out
);

   isic_pkg::isic_tm_t s_ff;
   isic_pkg::isic_tm_t nxt_s;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.fire = 1'b0;
      if (load_period_in)
      begin
         nxt_s.period = value_in;
         if (value_in == `ISIC_CNT_ZERO)
         begin
            nxt_s.state = isic_pkg::ISIC_TM_IDLE;
         end
         else if (s_ff.state == isic_pkg::ISIC_TM_IDLE)
         begin
            // an idle timer starts with one full interval
            nxt_s.state = isic_pkg::ISIC_TM_RUN;
            nxt_s.count = value_in;
         end
      end
      else if (load_delay_in)
      begin
         if (value_in == `ISIC_CNT_ZERO)
         begin
            nxt_s.state = isic_pkg::ISIC_TM_IDLE;
         end
         else
         begin
            nxt_s.state = isic_pkg::ISIC_TM_RUN;
            nxt_s.count = value_in;
         end
      end
      else
      begin
         case (s_ff.state)
            isic_pkg::ISIC_TM_IDLE:
            begin
               nxt_s.count = s_ff.count;
            end
            isic_pkg::ISIC_TM_RUN:
            begin
               if (tick_in)
               begin
                  if (s_ff.count <= `ISIC_CNT_ONE)
                  begin
                     nxt_s.fire = 1'b1;
                     nxt_s.count = s_ff.period;
                     if (s_ff.period == `ISIC_CNT_ZERO)
                     begin
                        nxt_s.state = isic_pkg::ISIC_TM_IDLE;
                     end
                  end
                  else
                  begin
                     nxt_s.count = s_ff.count - `ISIC_CNT_ONE;
                  end
               end
            end
            default:
            begin
               nxt_s.state = isic_pkg::ISIC_TM_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register, synchronous reset
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign fire_out = s_ff.fire;
   assign running_out = (s_ff.state == isic_pkg::ISIC_TM_RUN);

endmodule

// [design/isic_top.sv]
// Purpose: interrupt control for unit inputs and a scheduled interrupt
// Assumes: unit inputs synchronous to core_clk_in; rising edge = request
// Notes:   commands arrive as Avalon-MM register writes
//
// Notes on behaviour
// - selector 0-3 picks unit, 4 the timer
// - at most four units attached at once
// - eight low bits per unit, subroutines 0-31
// - code 0: data ones mask, zeros unmask
// - masked arrivals stay pending until unmasked or cleared by code 1
// - code 1 clears pending of masked selected bits
// - code 2 returns unit mask state
// - timer code 0 loads BCD period
// - zero period or delay cancels timer
// - timer code 1 loads first-interrupt delay
// - timer code 2 returns set period
`timescale 1ns/1ps
`include "isic_defs.svh"

module isic_top
#(
   parameter int TICK_CYCLES = `ISIC_TICK_NS / `ISIC_CLK_NS
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // avalon-mm slave
   input wire logic [`ISIC_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // interrupt input units
   input wire logic [`ISIC_UNITS*`ISIC_UNIT_IN_W-1:0] unit_bits_in,
   input wire logic [`ISIC_UNITS-1:0] unit_present_in,
   // dispatch to the program sequencer
   output logic dispatch_valid_out,
   output logic [`ISIC_SUB_W-1:0] dispatch_sub_out,
   input wire logic dispatch_ready_in,
   // interrupt output
   output logic irq_out
);

   isic_pkg::isic_top_t s_ff;
   isic_pkg::isic_top_t nxt_s;
   logic [`ISIC_SRC_W-1:0] src_bits;
   logic [`ISIC_SRC_W-1:0] present_bits;
   logic tm_fire;
   logic ld_period;
   logic ld_delay;
   logic [`ISIC_CNT_W-1:0] ld_value;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // four bcd digits, each must be 0-9
   function automatic logic isic_bcd_ok(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         if (v[i*4 +: 4] > 4'h9)
         begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // bcd hundredths of a second to a binary tick count
   function automatic logic [`ISIC_CNT_W-1:0] isic_bcd_bin(
      input logic [15:0] v);
      logic [`ISIC_CNT_W-1:0] r;
      r = {10'h000, v[15:12]} * 14'h03E8;
      r = r + {10'h000, v[11:8]} * 14'h0064;
      r = r + {10'h000, v[7:4]} * 14'h000A;
      r = r + {10'h000, v[3:0]};
      return r;
   endfunction

   // lowest set bit wins, so low subroutine numbers go first
   function automatic logic [`ISIC_SUB_W-1:0] isic_first(
      input logic [`ISIC_SRC_W-1:0] v);
      logic [`ISIC_SUB_W-1:0] r;
      r = `ISIC_NO_SUB;
      for (int i = `ISIC_SRC_W - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = `ISIC_SUB_W'(i);
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // unit input gathering: upper bits of each unit are dropped
   always_comb
   begin
      src_bits = '0;
      present_bits = '0;
      for (int u = 0; u < `ISIC_UNITS; u++)
      begin
         src_bits[u*`ISIC_BITS_PER_UNIT +: `ISIC_BITS_PER_UNIT] =
            unit_bits_in[u*`ISIC_UNIT_IN_W +: `ISIC_BITS_PER_UNIT];
         present_bits[u*`ISIC_BITS_PER_UNIT +: `ISIC_BITS_PER_UNIT] =
            {`ISIC_BITS_PER_UNIT{unit_present_in[u]}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main next-state process
   always_comb
   begin
      logic wr_now;
      logic [2:0] sel;
      logic [2:0] cc;
      logic [4:0] base;
      logic [`ISIC_SRC_W-1:0] clr;
      logic [`ISIC_SRC_W-1:0] rise;
      logic [`ISIC_SRC_W-1:0] ready_bits;
      logic [`ISIC_SUB_W-1:0] pick;
      logic [`ISIC_ST_W-1:0] ev;
      logic [`ISIC_ST_W-1:0] w1c;
      logic bad;
      wr_now = 1'b0;
      sel = 3'h0;
      cc = 3'h0;
      base = 5'h00;
      clr = '0;
      rise = '0;
      ready_bits = '0;
      pick = `ISIC_NO_SUB;
      ev = '0;
      w1c = '0;
      bad = 1'b0;
      nxt_s = s_ff;
      ld_period = 1'b0;
      ld_delay = 1'b0;
      ld_value = isic_bcd_bin(s_ff.data_word);

      // tick divider, one pulse per hundredth of a second
      nxt_s.tick = 1'b0;
      if (s_ff.div_cnt >= `ISIC_DIV_W'(TICK_CYCLES - 1))
      begin
         nxt_s.div_cnt = '0;
         nxt_s.tick = 1'b1;
      end
      else
      begin
         nxt_s.div_cnt = s_ff.div_cnt + `ISIC_DIV_W'(1);
      end

      // bus: one wait cycle, then the answer; ack drops the cycle after
      nxt_s.ack = (avs_read_in | avs_write_in) & ~s_ff.ack;
      if (avs_read_in && !s_ff.ack)
      begin
         case (avs_address_in)
            `ISIC_OFF_DATA: nxt_s.rdata = {16'h0000, s_ff.data_word};
            `ISIC_OFF_RESULT: nxt_s.rdata = {16'h0000, s_ff.result};
            `ISIC_OFF_STATUS: nxt_s.rdata = {28'h0000000, s_ff.status};
            `ISIC_OFF_IRQ_MASK: nxt_s.rdata = {28'h0000000, s_ff.irq_mask};
            `ISIC_OFF_PENDING: nxt_s.rdata = s_ff.pending;
            `ISIC_OFF_MASK: nxt_s.rdata = s_ff.mask;
            default: nxt_s.rdata = `ISIC_RST_WORD;
         endcase
      end
      wr_now = avs_write_in & s_ff.ack;

      // register writes taken at the edge that ends the cycle after the wait
      if (wr_now)
      begin
         case (avs_address_in)
            `ISIC_OFF_DATA:
            begin
               if (avs_byteenable_in[0])
               begin
                  nxt_s.data_word[7:0] = avs_writedata_in[7:0];
               end
               if (avs_byteenable_in[1])
               begin
                  nxt_s.data_word[15:8] = avs_writedata_in[15:8];
               end
            end
            `ISIC_OFF_STATUS:
            begin
               if (avs_byteenable_in[0])
               begin
                  w1c = avs_writedata_in[`ISIC_ST_W-1:0];
               end
            end
            `ISIC_OFF_IRQ_MASK:
            begin
               if (avs_byteenable_in[0])
               begin
                  nxt_s.irq_mask = avs_writedata_in[`ISIC_ST_W-1:0];
               end
            end
            default:
            begin
               nxt_s.irq_mask = s_ff.irq_mask;
            end
         endcase
      end

      // control instruction: a write to the command word executes it
      if (wr_now && avs_address_in == `ISIC_OFF_CMD && avs_byteenable_in[0])
      begin
         sel = avs_writedata_in[`ISIC_CMD_SEL_LSB +: 3];
         cc = avs_writedata_in[`ISIC_CMD_CC_LSB +: 3];
         base = {sel[1:0], 3'h0};
         if (sel <= `ISIC_SEL_LAST_UNIT)
         begin
            if (!unit_present_in[sel[1:0]])
            begin
               bad = 1'b1;
            end
            else if (cc == `ISIC_CC_MASK)
            begin
               nxt_s.mask[base +: 8] = s_ff.data_word[7:0];
            end
            else if (cc == `ISIC_CC_CLEAR)
            begin
               clr[base +: 8] = s_ff.data_word[7:0] &
                  s_ff.mask[base +: 8];
            end
            else if (cc == `ISIC_CC_READ)
            begin
               nxt_s.result = {8'h00, s_ff.mask[base +: 8]};
            end
            else
            begin
               bad = 1'b1;
            end
         end
         else if (sel == `ISIC_SEL_TIMER)
         begin
            if (cc == `ISIC_CC_READ)
            begin
               nxt_s.result = s_ff.period_bcd;
            end
            else if (!isic_bcd_ok(s_ff.data_word))
            begin
               bad = 1'b1;
            end
            else if (cc == `ISIC_CC_MASK)
            begin
               nxt_s.period_bcd = s_ff.data_word;
               ld_period = 1'b1;
            end
            else if (cc == `ISIC_CC_CLEAR)
            begin
               ld_delay = 1'b1;
            end
            else
            begin
               bad = 1'b1;
            end
         end
         else
         begin
            bad = 1'b1;
         end
         ev[`ISIC_ST_DONE] = ~bad;
         ev[`ISIC_ST_ERR] = bad;
      end

      // edges latch as pending whatever the mask; arrival beats clear
      rise = src_bits & ~s_ff.prev_in & present_bits;
      nxt_s.prev_in = src_bits;
      if (tm_fire)
      begin
         ev[`ISIC_ST_FIRE] = 1'b1;
      end

      // dispatch one at a time once the previous one is taken
      if (s_ff.disp_valid && dispatch_ready_in)
      begin
         nxt_s.disp_valid = 1'b0;
      end
      ready_bits = s_ff.pending & ~s_ff.mask & present_bits;
      pick = isic_first(ready_bits);
      nxt_s.pending = (s_ff.pending & ~clr) | rise;
      nxt_s.sched_pend = s_ff.sched_pend | tm_fire;
      if (!s_ff.disp_valid)
      begin
         if (pick != `ISIC_NO_SUB)
         begin
            nxt_s.disp_valid = 1'b1;
            nxt_s.disp_num = pick;
            nxt_s.pending[pick[4:0]] = rise[pick[4:0]];
            ev[`ISIC_ST_DISP] = 1'b1;
         end
         else if (s_ff.sched_pend)
         begin
            // scheduled interrupt ranks after all unit bits
            nxt_s.disp_valid = 1'b1;
            nxt_s.disp_num = `ISIC_SCHED_SUB;
            nxt_s.sched_pend = tm_fire;
            ev[`ISIC_ST_DISP] = 1'b1;
         end
      end

      // sticky status, a new event wins over a write-one clear
      nxt_s.status = (s_ff.status & ~w1c) | ev;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register, synchronous reset
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // scheduled timer
   isic_sched_timer u_timer
   (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(s_ff.tick),
      .load_period_in(ld_period),
      .load_delay_in(ld_delay),
      .value_in(ld_value),
      .fire_out(tm_fire),
      .running_out()
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s_ff.ack;
   assign avs_readdata_out = s_ff.rdata;
   assign dispatch_valid_out = s_ff.disp_valid;
   assign dispatch_sub_out = s_ff.disp_num;
   // level irq, high while any unmasked sticky bit is set
   assign irq_out = |(s_ff.status & s_ff.irq_mask);

endmodule

// [verif/isic_checker.sv]
// Purpose: port-level checks for the interrupt control block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to isic_top from the bench top file
`timescale 1ns/1ps
`include "isic_defs.svh"

module isic_checker
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // avalon-mm slave
   input wire logic [`ISIC_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // interrupt input units
   input wire logic [`ISIC_UNITS*`ISIC_UNIT_IN_W-1:0] unit_bits_in,
   input wire logic [`ISIC_UNITS-1:0] unit_present_in,
   // dispatch
   input wire logic dispatch_valid_out,
   input wire logic [`ISIC_SUB_W-1:0] dispatch_sub_out,
   input wire logic dispatch_ready_in,
   // interrupt output
   input wire logic irq_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking

   ////////////////////////////////////////////////////////////////////
   // steps of a bus access and of a dispatch handshake
   sequence s_req;
      avs_read_in || avs_write_in;
   endsequence
   sequence s_grant;
      dispatch_valid_out && dispatch_ready_in;
   endsequence
   sequence s_stall;
      dispatch_valid_out && !dispatch_ready_in;
   endsequence

   ////////////////////////////////////////////////////////////////////
   a_wait_one: assert property (disable iff (!rst_n_in)
      s_req ##0 avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("bus wait longer than one cycle");
   a_bus_release: assert property (disable iff (!rst_n_in)
      s_req ##0 !avs_waitrequest_out |=>
      avs_waitrequest_out || !(avs_read_in || avs_write_in))
      else $error("back to back access not waited");
   a_idle_nowait: assert property (disable iff (!rst_n_in)
      !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
      else $error("waitrequest without request");
   a_rdata_hold: assert property (disable iff (!rst_n_in)
      !avs_read_in |=> $stable(avs_readdata_out))
      else $error("read data moved without a read");
   a_valid_hold: assert property (disable iff (!rst_n_in)
      s_stall |=> dispatch_valid_out && $stable(dispatch_sub_out))
      else $error("dispatch dropped before accept");
   a_valid_drop: assert property (disable iff (!rst_n_in)
      s_grant |=> !dispatch_valid_out)
      else $error("dispatch not single");
   a_sub_range: assert property (disable iff (!rst_n_in)
      dispatch_valid_out |-> dispatch_sub_out <= `ISIC_SCHED_SUB)
      else $error("subroutine number out of range");
   // reset must silence dispatch valid, irq and read data by the next cycle
   a_reset_quiet: assert property (!rst_n_in |=>
      !dispatch_valid_out && !irq_out && avs_readdata_out == 32'h0)
      else $error("outputs busy after reset");
endmodule

// [verif/isic_unit_model.sv]
// Purpose: interrupt input units and a stalling program sequencer
// Assumes: unit requests are rising edges of unit bits
// Notes:   accepted subroutine numbers are queued for the bench
`timescale 1ns/1ps
`include "isic_defs.svh"

module isic_unit_model
#(
   parameter logic [3:0] PRESENT = 4'h7
)
(
   // clock
   input wire logic core_clk_in,
   // unit side
   output logic [`ISIC_UNITS*`ISIC_UNIT_IN_W-1:0] unit_bits_out,
   output logic [`ISIC_UNITS-1:0] unit_present_out,
   // sequencer side
   input wire logic dispatch_valid_in,
   input wire logic [`ISIC_SUB_W-1:0] dispatch_sub_in,
   output logic dispatch_ready_out
);
   logic [`ISIC_SUB_W-1:0] got[$];

   initial
   begin
      unit_bits_out = '0;
      dispatch_ready_out = 1'b0;
   end
   assign unit_present_out = PRESENT;

   // random ready so dispatches are stalled as a slow sequencer would
   always @(posedge core_clk_in)
   begin
      if (dispatch_valid_in && dispatch_ready_out)
         got.push_back(dispatch_sub_in);
      dispatch_ready_out <= 1'($urandom_range(1, 0));
   end

   // one-cycle pulse on a unit's 16 lines gives a rising edge
   task automatic raise(input int u, input logic [15:0] v);
      @(posedge core_clk_in);
      unit_bits_out[u*16 +: 16] <= v;
      @(posedge core_clk_in);
      unit_bits_out[u*16 +: 16] <= 16'h0000;
   endtask
endmodule

// [verif/test_input_and_scheduled_interrupt_control.sv]
// Purpose: self-checking bench of the interrupt control block
// Assumes: four-cycle timer tick, unit 3 absent
// Notes:   random commands plus hand-picked pending and timer cases
`timescale 1ns/1ps
`include "isic_defs.svh"

bind isic_top isic_checker isic_checker_inst (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .unit_bits_in(unit_bits_in), .unit_present_in(unit_present_in),
   .dispatch_valid_out(dispatch_valid_out),
   .dispatch_sub_out(dispatch_sub_out),
   .dispatch_ready_in(dispatch_ready_in), .irq_out(irq_out));

module test_input_and_scheduled_interrupt_control;
   localparam logic [3:0] PRESENT = 4'h7;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [`ISIC_ADDR_W-1:0] avs_address_in = '0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = '0;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [`ISIC_UNITS*`ISIC_UNIT_IN_W-1:0] unit_bits_in;
   logic [`ISIC_UNITS-1:0] unit_present_in;
   logic dispatch_valid_out;
   logic [`ISIC_SUB_W-1:0] dispatch_sub_out;
   logic dispatch_ready_in;
   logic irq_out;
   logic [31:0] q;
   logic [2:0] s;
   logic [2:0] c;
   logic [15:0] v;
   int bad_count = 0;
   int n_tests = 0;

   always #2.5 core_clk_in = ~core_clk_in;

   isic_top #(.TICK_CYCLES(4)) isic_top_inst (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .unit_bits_in(unit_bits_in), .unit_present_in(unit_present_in),
      .dispatch_valid_out(dispatch_valid_out),
      .dispatch_sub_out(dispatch_sub_out),
      .dispatch_ready_in(dispatch_ready_in), .irq_out(irq_out));

   isic_unit_model #(.PRESENT(PRESENT)) isic_unit_model_inst (
      .core_clk_in(core_clk_in), .unit_bits_out(unit_bits_in),
      .unit_present_out(unit_present_in),
      .dispatch_valid_in(dispatch_valid_out),
      .dispatch_sub_in(dispatch_sub_out),
      .dispatch_ready_out(dispatch_ready_in));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until the edge where waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      @(posedge core_clk_in);
      while (avs_waitrequest_out !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge core_clk_in);
      end
      chk(32'(n < 50), 32'h1);
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask

   // data word first, then the command word executes it
   task automatic cmd(input logic [2:0] sl, input logic [2:0] cc,
      input logic [15:0] d);
      bus(1'b1, `ISIC_OFF_DATA, {16'h0000, d});
      bus(1'b1, `ISIC_OFF_CMD, {25'h0, cc, 1'b0, sl});
   endtask

   task automatic wait_got(input int n);
      int k;
      k = 0;
      while (isic_unit_model_inst.got.size() < n && k < 400)
      begin
         @(posedge core_clk_in);
         k++;
      end
      chk(32'(isic_unit_model_inst.got.size()), 32'(n));
   endtask

   // done or error as the command should report it
   function automatic logic [1:0] exp_st(input logic [2:0] sl,
      input logic [2:0] cc, input logic [15:0] d);
      logic bad;
      bad = sl > 3'h4 || cc > 3'h2 || (sl < 3'h4 && !PRESENT[sl[1:0]]);
      if (sl == 3'h4 && cc != 3'h2)
         for (int i = 0; i < 4; i++)
            bad = bad || d[i*4 +: 4] > 4'h9;
      return bad ? 2'b10 : 2'b01;
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // watchdog well beyond the expected run length
   initial
   begin
      repeat (30000) @(posedge core_clk_in);
      bad_count++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(73));
      repeat (16) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      // reset values, unmapped place included
      for (int a = 0; a < 8; a++)
      begin
         bus(1'b0, 5'(a * 4), 32'h0);
         chk(q, 32'h0);
      end
      bus(1'b1, 5'h1C, 32'hFFFFFFFF);
      bus(1'b0, 5'h1C, 32'h0);
      chk(q, 32'h0);
      // first six walk selectors 0-5, the rest are random
      for (int i = 0; i < 24; i++)
      begin
         s = i < 6 ? 3'(i) : 3'($urandom_range(7, 0));
         c = i < 6 ? 3'h0 : 3'($urandom_range(3, 0));
         v = 16'($urandom);
         cmd(s, c, v);
         bus(1'b0, `ISIC_OFF_STATUS, 32'h0);
         chk({30'h0, q[1:0]}, {30'h0, exp_st(s, c, v)});
         if (s < 3'h3 && c == 3'h0)
         begin
            cmd(s, 3'h2, 16'h0000);
            bus(1'b0, `ISIC_OFF_RESULT, 32'h0);
            chk(q, {24'h0, v[7:0]});
         end
         // readback sets done too, so clear after it
         bus(1'b1, `ISIC_OFF_STATUS, 32'h0000000F);
      end
      // quiet the timer and units again
      cmd(3'h4, 3'h0, 16'h0000);
      cmd(3'h4, 3'h1, 16'h0000);
      for (int u = 0; u < 3; u++)
         cmd(3'(u), 3'h0, 16'h0000);
      repeat (40) @(posedge core_clk_in);
      isic_unit_model_inst.got.delete();
      // masked arrivals wait, upper byte and absent unit ignored
      cmd(3'h0, 3'h0, 16'h00FF);
      isic_unit_model_inst.raise(0, 16'hFFFF);
      isic_unit_model_inst.raise(3, 16'h00FF);
      repeat (3) @(posedge core_clk_in);
      bus(1'b0, `ISIC_OFF_PENDING, 32'h0);
      chk(q, 32'h000000FF);
      bus(1'b0, `ISIC_OFF_MASK, 32'h0);
      chk(q, 32'h000000FF);
      chk(32'(isic_unit_model_inst.got.size()), 32'h0);
      cmd(3'h0, 3'h1, 16'h000F);
      bus(1'b0, `ISIC_OFF_PENDING, 32'h0);
      chk(q, 32'h000000F0);
      isic_unit_model_inst.raise(1, 16'h0081);
      wait_got(2);
      chk(32'(isic_unit_model_inst.got[0]), 32'h8);
      chk(32'(isic_unit_model_inst.got[1]), 32'hF);
      cmd(3'h0, 3'h0, 16'h0000);
      wait_got(6);
      for (int k = 0; k < 4; k++)
         chk(32'(isic_unit_model_inst.got[k + 2]), 32'(k + 4));
      // timer period, readback, refusal and first delay
      cmd(3'h4, 3'h0, 16'h0003);
      cmd(3'h4, 3'h2, 16'h0000);
      bus(1'b0, `ISIC_OFF_RESULT, 32'h0);
      chk(q, 32'h00000003);
      bus(1'b1, `ISIC_OFF_STATUS, 32'h0000000F);
      cmd(3'h4, 3'h0, 16'h00A0);
      bus(1'b0, `ISIC_OFF_STATUS, 32'h0);
      chk({30'h0, q[1:0]}, 32'h2);
      // cancel the running period so only the delay can fire, once
      cmd(3'h4, 3'h0, 16'h0000);
      repeat (20) @(posedge core_clk_in);
      isic_unit_model_inst.got.delete();
      cmd(3'h4, 3'h1, 16'h0002);
      wait_got(1);
      chk(32'(isic_unit_model_inst.got[0]), 32'(`ISIC_SCHED_SUB));
      repeat (100) @(posedge core_clk_in);
      chk(32'(isic_unit_model_inst.got.size()), 32'h1);
      // interrupt line: raise, mask, clear
      bus(1'b1, `ISIC_OFF_STATUS, 32'h0000000F);
      bus(1'b1, `ISIC_OFF_IRQ_MASK, 32'h00000001);
      cmd(3'h0, 3'h2, 16'h0000);
      @(negedge core_clk_in);
      chk(32'(irq_out), 32'h1);
      bus(1'b1, `ISIC_OFF_IRQ_MASK, 32'h0);
      @(negedge core_clk_in);
      chk(32'(irq_out), 32'h0);
      bus(1'b1, `ISIC_OFF_IRQ_MASK, 32'h00000001);
      bus(1'b1, `ISIC_OFF_STATUS, 32'h00000001);
      @(negedge core_clk_in);
      chk(32'(irq_out), 32'h0);
      tally_and_finish();
   end
endmodule
